/* File: pds_sink_policy.sv */
// Sink policy engine: profile match, request build, bus window supervision.
// Assumes offers and handshakes come from a protocol layer on clk; attach and
// bus sense come from pins and are synchronised here.
`timescale 1ns/1ps
module pds_sink_policy #(
  parameter int NOFF     = 7,
  parameter int T_BLANK  = pds_pkg::T_SRC_READY_CYC
) (
  input  wire logic                       clk,            // 40 MHz clock
  input  wire logic                       rst_n,          // Sync reset, active low
  input  wire logic [7:0]                 wb_adr_i,       // Byte address
  input  wire logic [31:0]                wb_dat_i,       // Write data
  output logic      [31:0]                wb_dat_o,       // Read data
  input  wire logic                       wb_we_i,        // Write enable
  input  wire logic [3:0]                 wb_sel_i,       // Byte selects
  input  wire logic                       wb_cyc_i,       // Cycle
  input  wire logic                       wb_stb_i,       // Strobe
  output logic                            wb_ack_o,       // Acknowledge
  input  wire logic                       attach_pin,     // Source attached, async
  input  wire logic [pds_pkg::MW-1:0]     bus_sense_input,// Bus voltage in mV, async
  input  wire logic                       caps_valid,     // Offers valid pulse
  input  wire logic [2:0]                 caps_count,     // Number of offers
  input  wire logic [NOFF*pds_pkg::VW-1:0] offer_volt,    // Offer voltages, 50 mV
  input  wire logic [NOFF*pds_pkg::CW-1:0] offer_curr,    // Offer currents, 10 mA
  output logic                            req_valid,      // Request pending
  input  wire logic                       req_ready,      // Request taken
  output logic [pds_pkg::VW-1:0]          req_volt,       // Operating voltage
  output logic [pds_pkg::CW-1:0]          req_op_curr,    // Operating current
  output logic [pds_pkg::CW-1:0]          req_max_curr,   // Maximum current
  output logic                            req_mismatch,   // Capability mismatch
  output logic [1:0]                      req_profile,    // Matched profile, 0 none
  input  wire logic                       ps_ready,       // Source ready pulse
  output logic                            power_path_enable // Power path on
);
  import pds_pkg::*;

  localparam int BW = $clog2(T_BLANK + 1);

  function automatic logic [CW-1:0] cur_lut(input logic [3:0] idx,
                                            input logic [CW-1:0] custom);
    logic [CW-1:0] r;
    r = custom;
    unique case (idx)
      4'h1: r = 10'h032;
      4'h2: r = 10'h046;
      4'h3: r = 10'h064;
      4'h4: r = 10'h07d;
      4'h5: r = 10'h096;
      4'h6: r = 10'h0af;
      4'h7: r = 10'h0c8;
      4'h8: r = 10'h0e1;
      4'h9: r = 10'h0fa;
      4'ha: r = 10'h113;
      4'hb: r = 10'h12c;
      4'hc: r = 10'h15e;
      4'hd: r = 10'h190;
      4'he: r = 10'h1c2;
      4'hf: r = 10'h1f4;
      default: r = custom;
    endcase
    return r;
  endfunction

  function automatic logic [MW-1:0] pct_of(input logic [VW-1:0] ref_u,
                                           input int pct);
    logic [31:0] p;
    p = 32'(ref_u) * 32'(MV_PER_UNIT) * 32'(pct) / 32'(PCT_BASE);
    return p[MW-1:0];
  endfunction

  // Configuration registers
  logic [31:0]    ctrl_reg;
  logic [3:0]     idx1_reg;
  logic [VW-1:0]  v2_reg;
  logic [3:0]     idx2_reg;
  logic [VW-1:0]  v3_reg;
  logic [3:0]     idx3_reg;
  logic [CW-1:0]  custom_reg;
  logic [3:0]     shl_reg;
  logic [3:0]     shu_reg;

  // Pin synchronisers
  logic           att_s1_reg;
  logic           att_s2_reg;
  logic [MW-1:0]  vs_s1_reg;
  logic [MW-1:0]  vs_s2_reg;

  pds_state_type  state_reg;
  pds_state_type  state_next;
  logic [1:0]     sidx_reg;
  logic [2:0]     oidx_reg;
  logic [VW-1:0]  ref_reg;
  logic [1:0]     contract_reg;
  logic           ready_seen_reg;
  logic [BW-1:0]  blank_reg;
  logic           att_fail_reg;

  wire            wb_hit     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire            wb_wr      = wb_hit & wb_we_i;
  wire            req_fire   = req_valid & req_ready;
  wire            hv_only    = ctrl_reg[B_HV_ONLY];

  // Current profile under evaluation and current offer
  wire [VW-1:0]   s_volt = (sidx_reg == 2'd3) ? v3_reg :
                           (sidx_reg == 2'd2) ? v2_reg : V5_UNITS;
  wire [3:0]      s_idx  = (sidx_reg == 2'd3) ? idx3_reg :
                           (sidx_reg == 2'd2) ? idx2_reg : idx1_reg;
  wire [CW-1:0]   s_curr = cur_lut(s_idx, custom_reg);
  wire [VW-1:0]   o_volt = offer_volt[oidx_reg*VW +: VW];
  wire [CW-1:0]   o_curr = offer_curr[oidx_reg*CW +: CW];
  wire [CW-1:0]   o5_curr = offer_curr[CW-1:0];
  wire            pair_match = (s_volt == o_volt) && (s_curr <= o_curr);
  wire            last_offer = ({1'b0, oidx_reg} + 4'd1) >= {1'b0, caps_count};
  wire            prof_on2 = ctrl_reg[B_EN2];
  wire            prof_on3 = ctrl_reg[B_EN3];
  wire [1:0]      first_prof = prof_on3 ? 2'd3 : prof_on2 ? 2'd2 : 2'd1;
  wire [1:0]      lower_prof = (sidx_reg == 2'd3 && prof_on2) ? 2'd2 : 2'd1;

  // Valid window
  wire [MW-1:0]   up_lim  = pct_of(ref_reg, PCT_BASE + NOM_PCT + int'(shu_reg));
  wire [MW-1:0]   adj_lo  = pct_of(ref_reg, PCT_BASE - NOM_PCT - int'(shl_reg));
  wire            use_fixed = (state_reg != PDS_ATT_CHK) && (contract_reg < 2'd2);
  wire [MW-1:0]   lo_lim  = use_fixed ? VTH_FIXED_MV : adj_lo;
  wire            in_win  = (vs_s2_reg < up_lim) && (vs_s2_reg > lo_lim);
  wire            blank_done = (blank_reg == BW'(T_BLANK));
  wire            supervise = (state_reg == PDS_WAIT_CAPS) || (state_reg == PDS_EVAL) ||
                              (state_reg == PDS_RUN) ||
                              (state_reg == PDS_REQ && contract_reg == 2'd0);
  wire            fault = supervise & ~in_win;

  // Next state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      PDS_UNATT:
        if (att_s2_reg)
          state_next = PDS_ATT_CHK;
      PDS_ATT_CHK:
        if (!att_s2_reg)
          state_next = PDS_UNATT;
        else if (in_win)
          state_next = PDS_WAIT_CAPS;
      PDS_WAIT_CAPS, PDS_RUN:
        if (caps_valid)
          state_next = PDS_EVAL;
      PDS_EVAL:
        if (pair_match || (last_offer && sidx_reg == 2'd1))
          state_next = PDS_REQ;
      PDS_REQ:
        if (req_fire)
          state_next = PDS_BLANK;
      PDS_BLANK:
        if (blank_done)
          state_next = ready_seen_reg ? PDS_RUN : PDS_UNATT;
    endcase
    if (state_reg != PDS_UNATT && state_reg != PDS_ATT_CHK && (!att_s2_reg || fault))
      state_next = PDS_UNATT;
  end

  // Power path; on entry to run the new contract decides, not the old one
  wire [1:0] contract_eff = (state_reg == PDS_BLANK) ? req_profile : contract_reg;
  wire pp_next = (state_next != PDS_UNATT) && (state_next != PDS_ATT_CHK) &&
                 (!hv_only || (state_next == PDS_RUN && contract_eff >= 2'd2));

  // Register bus read mux
  wire [31:0] rd_status = {24'h0, 1'b0, req_valid, contract_reg, 1'b0, state_reg};
  wire [31:0] rd_data =
      (wb_adr_i == A_CTRL)   ? ctrl_reg :
      (wb_adr_i == A_PROF1)  ? {12'h0, idx1_reg, 16'h0} :
      (wb_adr_i == A_PROF2)  ? {12'h0, idx2_reg, 6'h0, v2_reg} :
      (wb_adr_i == A_PROF3)  ? {12'h0, idx3_reg, 6'h0, v3_reg} :
      (wb_adr_i == A_CUSTOM) ? {22'h0, custom_reg} :
      (wb_adr_i == A_SHIFT)  ? {20'h0, shu_reg, 4'h0, shl_reg} :
      (wb_adr_i == A_STATUS) ? rd_status :
      (wb_adr_i == A_REQ)    ? {1'b0, req_mismatch, req_profile, req_max_curr,
                                req_op_curr, req_volt[7:0]} : 32'h0;

  // Bus slave and configuration
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0;
      ctrl_reg   <= RST_CTRL;
      idx1_reg   <= RST_IDX;
      v2_reg     <= RST_V2;
      idx2_reg   <= RST_IDX;
      v3_reg     <= RST_V3;
      idx3_reg   <= RST_IDX;
      custom_reg <= RST_CUSTOM;
      shl_reg    <= RST_SHL;
      shu_reg    <= RST_SHU;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_data : 32'h0;
      if (wb_wr && wb_adr_i == A_CTRL && wb_sel_i[0])
        ctrl_reg[7:0] <= wb_dat_i[7:0];
      if (wb_wr && wb_adr_i == A_PROF1 && wb_sel_i[2])
        idx1_reg <= wb_dat_i[F_IDX_LO +: 4];
      if (wb_wr && wb_adr_i == A_PROF2)
      begin
        if (wb_sel_i[0] && wb_sel_i[1])
          v2_reg <= wb_dat_i[VW-1:0];
        if (wb_sel_i[2])
          idx2_reg <= wb_dat_i[F_IDX_LO +: 4];
      end
      if (wb_wr && wb_adr_i == A_PROF3)
      begin
        if (wb_sel_i[0] && wb_sel_i[1])
          v3_reg <= wb_dat_i[VW-1:0];
        if (wb_sel_i[2])
          idx3_reg <= wb_dat_i[F_IDX_LO +: 4];
      end
      if (wb_wr && wb_adr_i == A_CUSTOM && wb_sel_i[0] && wb_sel_i[1])
        custom_reg <= wb_dat_i[CW-1:0];
      if (wb_wr && wb_adr_i == A_SHIFT && wb_sel_i[0])
        shl_reg <= wb_dat_i[3:0];
      if (wb_wr && wb_adr_i == A_SHIFT && wb_sel_i[1])
        shu_reg <= wb_dat_i[F_SHU_LO +: 4];
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      att_s1_reg <= 1'b0;
      att_s2_reg <= 1'b0;
      vs_s1_reg  <= '0;
      vs_s2_reg  <= '0;
    end
    else
    begin
      att_s1_reg <= attach_pin;
      att_s2_reg <= att_s1_reg;
      vs_s1_reg  <= bus_sense_input;
      vs_s2_reg  <= vs_s1_reg;
    end
  end

  // Evaluation walk
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sidx_reg <= 2'd1;
      oidx_reg <= 3'd0;
    end
    else if (state_reg != PDS_EVAL)
    begin
      sidx_reg <= first_prof;
      oidx_reg <= 3'd0;
    end
    else if (!pair_match && last_offer)
    begin
      sidx_reg <= lower_prof;
      oidx_reg <= 3'd0;
    end
    else if (!pair_match)
      oidx_reg <= oidx_reg + 3'd1;
  end

  // Request build and handshake
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      req_valid    <= 1'b0;
      req_volt     <= '0;
      req_op_curr  <= '0;
      req_max_curr <= '0;
      req_mismatch <= 1'b0;
      req_profile  <= 2'd0;
    end
    else if (state_reg == PDS_EVAL && state_next == PDS_REQ)
    begin
      req_valid <= 1'b1;
      if (pair_match)
      begin
        req_volt     <= s_volt;
        req_op_curr  <= ctrl_reg[B_REQ_OFFER] ? o_curr : s_curr;
        req_max_curr <= o_curr;
        req_mismatch <= 1'b0;
        req_profile  <= sidx_reg;
      end
      else
      begin
        req_volt     <= V5_UNITS;
        req_op_curr  <= o5_curr;
        req_max_curr <= cur_lut(idx1_reg, custom_reg);
        req_mismatch <= 1'b1;
        req_profile  <= 2'd0;
      end
    end
    else if (req_fire || state_reg != PDS_REQ)
      req_valid <= 1'b0;
  end

  // Supervision reference, contract and blanking
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg         <= PDS_UNATT;
      ref_reg           <= V5_UNITS;
      contract_reg      <= 2'd0;
      ready_seen_reg    <= 1'b0;
      blank_reg         <= '0;
      power_path_enable <= 1'b0;
    end
    else
    begin
      state_reg         <= state_next;
      power_path_enable <= pp_next;
      if (state_next == PDS_UNATT || state_next == PDS_ATT_CHK)
      begin
        ref_reg      <= V5_UNITS;
        contract_reg <= 2'd0;
      end
      if (state_reg != PDS_BLANK)
      begin
        blank_reg      <= '0;
        ready_seen_reg <= 1'b0;
      end
      else
      begin
        blank_reg <= blank_reg + BW'(1);
        if (ps_ready)
          ready_seen_reg <= 1'b1;
      end
      if (state_reg == PDS_BLANK && state_next == PDS_RUN)
      begin
        ref_reg      <= req_volt;
        contract_reg <= (req_profile == 2'd0) ? 2'd1 : req_profile;
      end
    end
  end
endmodule // pds_sink_policy

/* File: pds_pkg.sv */
// Constants, register map and state type of the autonomous sink policy block.
// Assumes a 40 MHz clock and a 32-bit classic Wishbone register bus.
// Operation
// - Three sink profiles: one mandatory lowest, two medium, three highest priority.
// - Profile one voltage is fixed at 5 V.
// - Profiles two and three take 5 V to 20 V in 50 mV steps.
// - Each profile current picks one of fifteen fixed entries, 0.5 A to 5 A.
// - One extra entry is a shared custom current, 10 mA to 5 A.
// - Evaluate highest profile first, voltage checked before current.
// - Match needs equal voltage and sink current not above offer current.
// - Stop at the first match; skip remaining offers and lower profiles.
// - Match request: sink voltage, sink current operating, offer current maximum.
// - Send request; source accepts, moves voltage, then signals ready.
// - No match ends in an explicit 5 V contract.
// - No match: mismatch flag, 5 V offer current operating, profile one maximum.
// - Control bit picks sink or offer current as matched operating current.
// - At attachment an out-of-window bus voltage blocks connection and power path.
// - After attachment under or overvoltage returns to unattached, power off; not checked in the request state once a contract is held.
// - Fixed disconnect threshold at 5 V operation is 3.3 V.
// - Lower limit is reference minus 5%, shifted a further 1% to 15%.
// - Upper limit is reference plus 5%, shifted a further 1% to 15%.
// - Attach uses both limits; 5 V uses fixed threshold; profiles two/three both.
// - Reference is 5 V at attach, negotiated voltage after each transition.
// - Supervision paused for tSrcReady, 285 ms, then new limits checked.
// - Both shift coefficients load defaults and are set independently.
// - With high voltage only set, power path needs a profile two/three contract.
package pds_pkg;
  localparam int          VW             = 10;
  localparam int          CW             = 10;
  localparam int          MW             = 15;
  localparam logic [VW-1:0] V5_UNITS     = 10'h064;
  localparam int          MV_PER_UNIT    = 50;
  localparam logic [MW-1:0] VTH_FIXED_MV = 15'h0ce4;
  localparam int          NOM_PCT        = 5;
  localparam int          PCT_BASE       = 100;
  localparam int          T_SRC_READY_MS = 285;
  localparam int          CLK_KHZ        = 40000;
  localparam int          T_SRC_READY_CYC = T_SRC_READY_MS * CLK_KHZ;
  localparam logic [7:0]  A_CTRL         = 8'h00;
  localparam logic [7:0]  A_PROF1        = 8'h04;
  localparam logic [7:0]  A_PROF2        = 8'h08;
  localparam logic [7:0]  A_PROF3        = 8'h0c;
  localparam logic [7:0]  A_CUSTOM       = 8'h10;
  localparam logic [7:0]  A_SHIFT        = 8'h14;
  localparam logic [7:0]  A_STATUS       = 8'h18;
  localparam logic [7:0]  A_REQ          = 8'h1c;
  localparam int          B_REQ_OFFER    = 0;
  localparam int          B_HV_ONLY      = 1;
  localparam int          B_EN2          = 2;
  localparam int          B_EN3          = 3;
  localparam int          F_IDX_LO       = 16;
  localparam int          F_SHU_LO       = 8;
  localparam logic [31:0] RST_CTRL       = 32'h0000_0000;
  localparam logic [VW-1:0] RST_V2       = 10'h0b4;
  localparam logic [VW-1:0] RST_V3       = 10'h190;
  localparam logic [3:0]  RST_IDX        = 4'h5;
  localparam logic [CW-1:0] RST_CUSTOM   = 10'h064;
  localparam logic [3:0]  RST_SHL        = 4'h0;
  localparam logic [3:0]  RST_SHU        = 4'h0;
  typedef enum logic [2:0] {
    PDS_UNATT, PDS_ATT_CHK, PDS_WAIT_CAPS, PDS_EVAL, PDS_REQ, PDS_BLANK, PDS_RUN
  } pds_state_type;
endpackage

/* File: pds_sink_policy_properties.sv */
// Concurrent checks on the ports of the sink policy block, plus its bind.
// Assumes a single clk domain with synchronous active-low rst_n.
`timescale 1ns/1ps
module pds_sink_policy_properties #(
  parameter int NOFF    = 7,
  parameter int T_BLANK = 20
) (
  input wire logic                       clk,               // Clock
  input wire logic                       rst_n,             // Reset
  input wire logic                       wb_cyc_i,          // Cycle
  input wire logic                       wb_stb_i,          // Strobe
  input wire logic                       wb_ack_o,          // Ack
  input wire logic [31:0]                wb_dat_o,          // Read data
  input wire logic                       attach_pin,        // Attach
  input wire logic [pds_pkg::MW-1:0]     bus_sense_input,   // Bus mV
  input wire logic                       req_valid,         // Request
  input wire logic                       req_ready,         // Taken
  input wire logic [pds_pkg::VW-1:0]     req_volt,          // Volt
  input wire logic [pds_pkg::CW-1:0]     req_op_curr,       // Op current
  input wire logic [pds_pkg::CW-1:0]     req_max_curr,      // Max current
  input wire logic                       req_mismatch,      // Mismatch
  input wire logic [1:0]                 req_profile,       // Profile
  input wire logic                       power_path_enable  // Power path
);
  import pds_pkg::*;
  logic [15:0] low_cnt_reg;
  logic [15:0] low_cnt_next;
  // Counts cycles of bus below the fixed threshold, saturating
  assign low_cnt_next = (bus_sense_input >= VTH_FIXED_MV) ? 16'h0000 :
                        (low_cnt_reg == 16'hffff) ? low_cnt_reg : low_cnt_reg + 16'h0001;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      low_cnt_reg <= 16'h0000;
    else
      low_cnt_reg <= low_cnt_next;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_req_hold:
    assert property (req_valid && !req_ready |=> req_valid && $stable(req_volt)
      && $stable(req_op_curr) && $stable(req_max_curr)) else $error("request moved");
  a_req_drop:
    assert property (req_valid && req_ready |=> !req_valid) else $error("request kept");
  a_mismatch_5v:
    assert property (req_valid && req_mismatch |-> req_volt == V5_UNITS
      && req_profile == 2'h0) else $error("mismatch request not at 5 V");
  a_prof1_5v:
    assert property (req_valid && req_profile == 2'h1 |-> req_volt == V5_UNITS)
      else $error("profile one request not at 5 V");
  a_match_curr:
    assert property (req_valid && !req_mismatch |-> req_profile != 2'h0
      && req_op_curr <= req_max_curr) else $error("matched request currents wrong");
  a_path_attach:
    assert property (!attach_pin [*4] |-> !power_path_enable)
      else $error("power path on while detached");
  a_under_off:
    assert property (int'(low_cnt_reg) > T_BLANK + 8 |-> !power_path_enable)
      else $error("power path on under fixed threshold");
  c_mismatch: cover property (req_valid && req_mismatch);
  c_prof3: cover property (req_valid && req_profile == 2'h3);
  c_slow: cover property (req_valid && !req_ready [*3]);
  c_power: cover property ($rose(power_path_enable));
endmodule // pds_sink_policy_properties

bind pds_sink_policy pds_sink_policy_properties #(.NOFF(NOFF), .T_BLANK(T_BLANK)) u_props (
  .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .attach_pin, .bus_sense_input,
  .req_valid, .req_ready, .req_volt, .req_op_curr, .req_max_curr, .req_mismatch,
  .req_profile, .power_path_enable);

/* File: pds_source_model.sv */
// Behavioural source port: offers 5 V 3 A, 9 V 3 A, 15 V 2 A and answers requests.
// Assumes the bench calls its tasks; reply delay is set through slow.
`timescale 1ns/1ps
module pds_source_model #(
  parameter int NOFF = 7
) (
  input  wire logic                         clk,             // Clock
  output logic                              attach_pin,      // Attach
  output logic [pds_pkg::MW-1:0]            bus_sense_input, // Bus mV
  output logic                              caps_valid,      // Offers pulse
  output logic [2:0]                        caps_count,      // Offer count
  output logic [NOFF*pds_pkg::VW-1:0]       offer_volt,      // Volts
  output logic [NOFF*pds_pkg::CW-1:0]       offer_curr,      // Currents
  input  wire logic                         req_valid,       // Request
  input  wire logic [pds_pkg::VW-1:0]       req_volt,        // Request volt
  output logic                              req_ready,       // Taken
  output logic                              ps_ready         // Ready pulse
);
  import pds_pkg::*;
  int   slow = 0;
  int   cnt  = 0;
  logic busy = 1'b0;
  initial
  begin
    attach_pin = 1'b0;
    bus_sense_input = '0;
    caps_valid = 1'b0;
    caps_count = 3'h3;
    req_ready = 1'b0;
    ps_ready = 1'b0;
    offer_volt = (NOFF*VW)'({10'h12c, 10'h0b4, 10'h064});
    offer_curr = (NOFF*CW)'({10'h0c8, 10'h12c, 10'h12c});
  end
  // Accept after slow cycles, move the bus, then signal ready
  always @(posedge clk)
  begin
    req_ready <= 1'b0;
    ps_ready  <= 1'b0;
    if (!busy && req_valid && !req_ready)
    begin
      cnt <= cnt + 1;
      if (cnt >= slow)
      begin
        req_ready <= 1'b1;
        busy      <= 1'b1;
        cnt       <= 0;
      end
    end
    else if (busy)
    begin
      cnt <= cnt + 1;
      if (cnt == 2)
        bus_sense_input <= MW'(req_volt * MV_PER_UNIT);
      if (cnt == 4)
      begin
        ps_ready <= 1'b1;
        busy     <= 1'b0;
        cnt      <= 0;
      end
    end
  end
  task automatic drive_bus(input logic [MW-1:0] mv);
    @(posedge clk);
    attach_pin      <= 1'b1;
    bus_sense_input <= mv;
  endtask
  task automatic send_caps();
    @(posedge clk);
    caps_valid <= 1'b1;
    @(posedge clk);
    caps_valid <= 1'b0;
  endtask
  task automatic set_offers(input logic [2:0] n, input logic [NOFF*VW-1:0] v,
                            input logic [NOFF*CW-1:0] c);
    @(posedge clk);
    caps_count <= n;
    offer_volt <= v;
    offer_curr <= c;
  endtask
  task automatic detach();
    @(posedge clk);
    attach_pin      <= 1'b0;
    bus_sense_input <= '0;
  endtask
endmodule // pds_source_model

/* File: pds_sink_policy_tb.sv */
// Self-checking bench: registers over Wishbone, negotiations, bus window.
// Assumes the source model answers every request; blanking shortened to 20.
`timescale 1ns/1ps
module pds_sink_policy_tb;
  import pds_pkg::*;
  localparam int NOFF = 7;
  logic                   clk, rst_n, wb_we_i, wb_cyc_i, wb_ack_o, attach_pin, caps_valid;
  logic                   req_valid, req_ready, req_mismatch, ps_ready, power_path_enable;
  logic                   wb_stb_i;
  logic [7:0]             wb_adr_i;
  logic [3:0]             wb_sel_i;
  logic [31:0]            wb_dat_i, wb_dat_o;
  logic [MW-1:0]          bus_sense_input;
  logic [2:0]             caps_count;
  logic [NOFF*VW-1:0]     offer_volt;
  logic [NOFF*CW-1:0]     offer_curr;
  logic [VW-1:0]          req_volt;
  logic [CW-1:0]          req_op_curr, req_max_curr;
  logic [1:0]             req_profile;
  int                     miscompares = 0;
  int                     num_checks = 0;
  int                     cycles = 0;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
  logic [31:0] rv [8] = '{32'h0, 32'h00050000, 32'h000500b4, 32'h00050190, 32'h64, 0, 0, 0};
  pds_sink_policy #(.NOFF(NOFF), .T_BLANK(20)) dut (.clk, .rst_n, .wb_adr_i, .wb_dat_i,
    .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .attach_pin,
    .bus_sense_input, .caps_valid, .caps_count, .offer_volt, .offer_curr, .req_valid,
    .req_ready, .req_volt, .req_op_curr, .req_max_curr, .req_mismatch, .req_profile,
    .ps_ready, .power_path_enable);
  pds_source_model #(.NOFF(NOFF)) src (.clk, .attach_pin, .bus_sense_input, .caps_valid,
    .caps_count, .offer_volt, .offer_curr, .req_valid, .req_volt, .req_ready, .ps_ready);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk);
    wb_adr_i <= a;
    wb_we_i  <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk("ack", 32'h1, 32'(n < 50));
  endtask
  task automatic wait_state(input logic [2:0] s);
    logic [31:0] q;
    int n;
    n = 0;
    do
    begin
      wb(A_STATUS, 1'b0, 32'h0, q);
      n++;
    end
    while (q[2:0] !== s && n < 300);
    chk("state", 32'(s), 32'(q[2:0]));
  endtask
  task automatic neg(input logic [9:0] v, o, m, input logic [1:0] p, input logic mm);
    src.send_caps();
    wait_state(3'h6);
    chk("volt", 32'(v), 32'(req_volt));
    chk("op", 32'(o), 32'(req_op_curr));
    chk("max", 32'(m), 32'(req_max_curr));
    chk("prof", 32'(p), 32'(req_profile));
    chk("mism", 32'(mm), 32'(req_mismatch));
  endtask
  initial
  begin : main
    logic [31:0] q;
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hf;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i])
    begin
      wb(ra[i], 1'b0, 32'h0, q);
      chk("reset value", rv[i], q);
    end
    wb_sel_i <= 4'h2;
    wb(A_SHIFT, 1'b1, 32'h00000307, q);
    wb_sel_i <= 4'hf;
    wb(A_SHIFT, 1'b0, 32'h0, q);
    chk("shift sel", 32'h300, q);
    wb(A_SHIFT, 1'b1, 32'h00000302, q);
    wb(A_SHIFT, 1'b0, 32'h0, q);
    chk("shift", 32'h302, q);
    wb(A_PROF2, 1'b1, 32'h000900b4, q);
    wb(A_PROF3, 1'b1, 32'h0007012e, q);
    wb(A_CTRL, 1'b1, 32'h0000000c, q);
    $display("test registers done");
    src.drive_bus(15'h157c);
    repeat (10) @(posedge clk);
    wb(A_STATUS, 1'b0, 32'h0, q);
    chk("attach hold", 32'h1, q);
    chk("pwr", 32'h0, 32'(power_path_enable));
    src.drive_bus(15'h1388);
    wait_state(3'h2);
    neg(10'h0b4, 10'h0fa, 10'h12c, 2'h2, 1'b0);
    wb(A_STATUS, 1'b0, 32'h0, q);
    chk("contract", 32'h2, 32'(q[5:4]));
    chk("pwr", 32'h1, 32'(power_path_enable));
    $display("test match done");
    src.slow = 5;
    wb(A_CTRL, 1'b1, 32'h0000000d, q);
    neg(10'h0b4, 10'h12c, 10'h12c, 2'h2, 1'b0);
    src.slow = 0;
    wb(A_CTRL, 1'b1, 32'h0000000c, q);
    wb(A_PROF3, 1'b1, 32'h0000012c, q);
    wb(A_CUSTOM, 1'b1, 32'h000000c8, q);
    neg(10'h12c, 10'h0c8, 10'h0c8, 2'h3, 1'b0);
    $display("test priority done");
    src.drive_bus(15'h3f46);
    wait_state(3'h6);
    src.drive_bus(15'h3688);
    wait_state(3'h6);
    src.drive_bus(15'h3674);
    wait_state(3'h1);
    chk("pwr", 32'h0, 32'(power_path_enable));
    $display("test window done");
    wb(A_PROF1, 1'b1, 32'h000f0000, q);
    wb(A_CTRL, 1'b1, 32'h00000002, q);
    src.set_offers(3'h2, (NOFF*VW)'({10'h0b4, 10'h064}),
                   (NOFF*CW)'({10'h12c, 10'h0fa}));
    src.drive_bus(15'h1388);
    wait_state(3'h2);
    neg(10'h064, 10'h0fa, 10'h1f4, 2'h0, 1'b1);
    wb(A_STATUS, 1'b0, 32'h0, q);
    chk("contract", 32'h1, 32'(q[5:4]));
    chk("pwr", 32'h0, 32'(power_path_enable));
    wb(A_CTRL, 1'b1, 32'h00000000, q);
    src.drive_bus(15'h0d48);
    repeat (10) @(posedge clk);
    chk("pwr", 32'h1, 32'(power_path_enable));
    src.drive_bus(15'h0c80);
    wait_state(3'h1);
    chk("pwr", 32'h0, 32'(power_path_enable));
    wb(A_PROF1, 1'b1, 32'h00030000, q);
    src.drive_bus(15'h1388);
    wait_state(3'h2);
    neg(10'h064, 10'h064, 10'h0fa, 2'h1, 1'b0);
    chk("pwr", 32'h1, 32'(power_path_enable));
    src.detach();
    wait_state(3'h0);
    chk("pwr", 32'h0, 32'(power_path_enable));
    $display("test no match done");
    print_verdict();
  end
endmodule // pds_sink_policy_tb
